// [rtl/sacg_cfg.svh]
// Constants for the step axis command gate: widths, codes and message numbers
`ifndef SACG_CFG_SVH
`define SACG_CFG_SVH
`define SACG_POS_W 32
`define SACG_SPD_W 16
`define SACG_CMV_W 16
`define SACG_CMV_UNITY 16'h03E8
`define SACG_MSG_W 8
`define SACG_MSG_NONE 8'h00
`define SACG_MSG_UNCONF 8'h01
`define SACG_MSG_BLOCKED 8'h02
`define SACG_MSG_DRIVE 8'h03
`define SACG_MSG_MODE 8'h04
`define SACG_MSG_LIMIT 8'h05
`define SACG_MSG_UNREF 8'h06
`define SACG_MSG_SPEED 8'h07
`define SACG_MSG_EOR 8'h08
`define SACG_MSG_DDLOCK 8'h09
`endif

// [rtl/sacg_gate.sv]
// Command admission, speed clamping and fault classification for one step axis
`include "sacg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sacg_gate
  import sacg_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic configured,
  input wire logic blocking_error,
  input wire logic drive_enable,
  input wire logic stop_request,
  input wire logic fault_acknowledge,
  input wire sacg_mode_t mode_select,
  input wire logic cmd_valid,
  input wire sacg_cmd_t cmd_kind,
  input wire logic cmd_dir_up,
  input wire logic signed [`SACG_POS_W-1:0] cmd_position,
  input wire logic [`SACG_SPD_W-1:0] cmd_speed,
  input wire logic sequence_step,
  input wire logic sequence_option,
  input wire logic signed [`SACG_POS_W-1:0] soft_limit_low,
  input wire logic signed [`SACG_POS_W-1:0] soft_limit_high,
  input wire logic [`SACG_SPD_W-1:0] max_feed_speed,
  input wire logic [`SACG_CMV_W-1:0] speed_modulation_coefficient,
  input wire logic monitor_inversion,
  input wire logic drive_ready_pin,
  input wire logic eor_low_pin,
  input wire logic eor_high_pin,
  input wire logic internal_fault,
  input wire logic step_done,
  input wire logic signed [`SACG_POS_W-1:0] current_position,
  input wire logic referenced_set,
  input wire logic parameter_write_request,
  input wire logic adjustment_exchange_pending,
  output logic param_write_accept,
  output logic cmd_accept,
  output logic cmd_refuse,
  output logic moving,
  output logic axis_up,
  output logic signed [`SACG_POS_W-1:0] target_position,
  output logic [`SACG_SPD_W-1:0] run_speed,
  output logic referenced,
  output sacg_cause_t refuse_cause,
  output logic [`SACG_MSG_W-1:0] refuse_msg,
  output logic fault_internal,
  output logic fault_external,
  output logic fault_other
);
  // Three-stage synchronisers for the pins; the first stage feeds only the second
  logic [2:0] drv_s_reg, eorl_s_reg, eorh_s_reg;
  logic drv_reg, eorl_reg, eorh_reg, ack_d_reg, ddlock_reg;
  sacg_state_t state_reg;
  logic signed [`SACG_POS_W-1:0] abs_pos_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      drv_s_reg <= 3'h0;
      eorl_s_reg <= 3'h0;
      eorh_s_reg <= 3'h0;
    end else begin
      drv_s_reg <= {drv_s_reg[1:0], drive_ready_pin};
      eorl_s_reg <= {eorl_s_reg[1:0], eor_low_pin};
      eorh_s_reg <= {eorh_s_reg[1:0], eor_high_pin};
    end
  end

  // A change is taken only once stages two and three agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      drv_reg <= 1'b0;
      eorl_reg <= 1'b0;
      eorh_reg <= 1'b0;
    end else begin
      if (drv_s_reg[1] == drv_s_reg[2]) drv_reg <= drv_s_reg[2];
      if (eorl_s_reg[1] == eorl_s_reg[2]) eorl_reg <= eorl_s_reg[2];
      if (eorh_s_reg[1] == eorh_s_reg[2]) eorh_reg <= eorh_s_reg[2];
    end
  end

  // Inverted monitor reads an open input as healthy, so no translator is needed
  logic drive_ok;
  assign drive_ok = monitor_inversion ? !drv_reg : drv_reg;

  // Running into an active end-of-run; resting on one is no fault, so a return move stays open
  logic eor_hit;
  assign eor_hit = (eorl_reg && !axis_up) || (eorh_reg && axis_up);

  // Relative target from the current position; wide sum avoids wrap
  logic signed [`SACG_POS_W:0] rel_wide;
  logic signed [`SACG_POS_W-1:0] tgt;
  logic in_limits, rel_ovf;
  assign rel_wide = {current_position[`SACG_POS_W-1], current_position}
                  + {cmd_position[`SACG_POS_W-1], cmd_position};
  assign rel_ovf = rel_wide[`SACG_POS_W] != rel_wide[`SACG_POS_W-1];
  always_comb begin
    tgt = cmd_position;
    in_limits = 1'b1;
    case (cmd_kind)
      SACG_CMD_ABS: begin
        in_limits = cmd_position >= soft_limit_low && cmd_position <= soft_limit_high;
      end
      SACG_CMD_REL: begin
        tgt = rel_wide[`SACG_POS_W-1:0];
        in_limits = !rel_ovf && tgt >= soft_limit_low && tgt <= soft_limit_high;
      end
      SACG_CMD_CONT: begin
        // Without the sequence option a continuous move runs to the soft limit
        tgt = cmd_dir_up ? soft_limit_high : soft_limit_low;
      end
      default: begin
        tgt = cmd_position;
      end
    endcase
  end

  // Direction of the request, used for the end-of-run check
  logic dir_up;
  always_comb begin
    case (cmd_kind)
      SACG_CMD_ABS, SACG_CMD_REL: dir_up = tgt > current_position;
      default: dir_up = cmd_dir_up;
    endcase
  end

  // Checks in priority order; the first failing one names the cause
  sacg_cause_t cause;
  logic [`SACG_MSG_W-1:0] msg;
  always_comb begin
    cause = SACG_CAUSE_NONE;
    msg = `SACG_MSG_NONE;
    if (!configured) begin
      cause = SACG_CAUSE_UNCONF;
      msg = `SACG_MSG_UNCONF;
    end else if (blocking_error || fault_internal || fault_external || fault_other) begin
      cause = SACG_CAUSE_BLOCKED;
      msg = `SACG_MSG_BLOCKED;
    end else if (!drive_enable || stop_request || !drive_ok) begin
      cause = SACG_CAUSE_DRIVE;
      msg = `SACG_MSG_DRIVE;
    end else if (mode_select != SACG_MODE_AUTO && mode_select != SACG_MODE_MANUAL) begin
      cause = (mode_select == SACG_MODE_DIRECT && ddlock_reg) ? SACG_CAUSE_DDLOCK
                                                               : SACG_CAUSE_MODE;
      msg = (mode_select == SACG_MODE_DIRECT && ddlock_reg) ? `SACG_MSG_DDLOCK : `SACG_MSG_MODE;
    end else if (!referenced && cmd_kind != SACG_CMD_REF && cmd_kind != SACG_CMD_INCH) begin
      cause = SACG_CAUSE_UNREF;
      msg = `SACG_MSG_UNREF;
    end else if (!in_limits) begin
      cause = SACG_CAUSE_LIMIT;
      msg = `SACG_MSG_LIMIT;
    end else if (cmd_speed > max_feed_speed) begin
      cause = SACG_CAUSE_SPEED;
      msg = `SACG_MSG_SPEED;
    end else if ((eorl_reg && !dir_up) || (eorh_reg && dir_up)) begin
      cause = SACG_CAUSE_EOR;
      msg = `SACG_MSG_EOR;
    end
  end

  assign cmd_accept = cmd_valid && cause == SACG_CAUSE_NONE;
  assign cmd_refuse = cmd_valid && cause != SACG_CAUSE_NONE;
  assign param_write_accept = parameter_write_request && !adjustment_exchange_pending;

  // Modulated speed, clamped to the ceiling; product kept at full width
  logic [`SACG_SPD_W+`SACG_CMV_W-1:0] mod_prod;
  logic [`SACG_SPD_W+`SACG_CMV_W-1:0] mod_spd;
  logic [`SACG_SPD_W-1:0] base_spd_reg;
  assign mod_prod = base_spd_reg * speed_modulation_coefficient;
  assign mod_spd = mod_prod / `SACG_CMV_UNITY;

  // Motion registers load only on an accepted command; the state also drops back to idle on its own
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SACG_IDLE;
      target_position <= '0;
      base_spd_reg <= '0;
      axis_up <= 1'b0;
    end else if (cmd_accept) begin
      state_reg <= SACG_MOVING;
      target_position <= tgt;
      base_spd_reg <= cmd_speed;
      axis_up <= dir_up;
    end else begin
      case (state_reg)
        SACG_MOVING: begin
          // A sequence step ends any move only when the option is on
          if (step_done || stop_request || !drive_enable || eor_hit ||
              (sequence_step && sequence_option))
            state_reg <= SACG_IDLE;
        end
        default: state_reg <= SACG_IDLE;
      endcase
    end
  end
  assign moving = state_reg == SACG_MOVING;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) run_speed <= '0;
    else if (mod_spd > {{`SACG_CMV_W{1'b0}}, max_feed_speed}) run_speed <= max_feed_speed;
    else run_speed <= mod_spd[`SACG_SPD_W-1:0];
  end

  // Reference kept until the drive is disabled; a refused command cannot touch it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) referenced <= 1'b0;
    else if (referenced_set) referenced <= 1'b1;
    else if (!drive_enable) referenced <= 1'b0;
  end

  // Only a rising edge of acknowledge clears faults; a held level does nothing
  logic ack_rise, dd_overrun;
  assign ack_rise = fault_acknowledge && !ack_d_reg;
  assign dd_overrun = mode_select == SACG_MODE_DIRECT && referenced &&
                      (current_position < soft_limit_low || current_position > soft_limit_high);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ack_d_reg <= 1'b0;
    else ack_d_reg <= fault_acknowledge;
  end

  // Direct-drive overrun locks further direct moves; set wins over acknowledge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ddlock_reg <= 1'b0;
    else if (dd_overrun) ddlock_reg <= 1'b1;
    else if (ack_rise && !referenced) ddlock_reg <= 1'b0;
  end

  // Sticky fault classes; an event in the acknowledge cycle is kept
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fault_internal <= 1'b0;
      fault_external <= 1'b0;
      fault_other <= 1'b0;
    end else begin
      fault_internal <= internal_fault || (fault_internal && !ack_rise);
      fault_external <= !drive_ok || (moving && eor_hit) || (moving && stop_request)
                        || (fault_external && !ack_rise);
      fault_other <= dd_overrun || (fault_other && !ack_rise);
    end
  end

  // Last refusal cause and message held for readout
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      refuse_cause <= SACG_CAUSE_NONE;
      refuse_msg <= `SACG_MSG_NONE;
    end else if (cmd_refuse) begin
      refuse_cause <= cause;
      refuse_msg <= msg;
    end
  end
endmodule
`default_nettype wire

// [rtl/sacg_pkg.sv]
// Types for the step axis command gate
package sacg_pkg;
  typedef enum logic [2:0] {
    SACG_CMD_ABS, SACG_CMD_REL, SACG_CMD_REF, SACG_CMD_INCH, SACG_CMD_CONT
  } sacg_cmd_t;
  typedef enum logic [1:0] {
    SACG_MODE_OFF, SACG_MODE_AUTO, SACG_MODE_MANUAL, SACG_MODE_DIRECT
  } sacg_mode_t;
  typedef enum logic [3:0] {
    SACG_CAUSE_NONE, SACG_CAUSE_UNCONF, SACG_CAUSE_BLOCKED, SACG_CAUSE_DRIVE,
    SACG_CAUSE_MODE, SACG_CAUSE_LIMIT, SACG_CAUSE_UNREF, SACG_CAUSE_SPEED,
    SACG_CAUSE_EOR, SACG_CAUSE_DDLOCK
  } sacg_cause_t;
  typedef enum logic {SACG_IDLE, SACG_MOVING} sacg_state_t;
endpackage

// [tb/sacg_gate_assertions.sv]
// Port-level assertions for the step axis command gate
`include "sacg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sacg_gate_checker
  import sacg_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic configured,
  input wire logic drive_enable,
  input wire logic stop_request,
  input wire logic cmd_valid,
  input wire sacg_cmd_t cmd_kind,
  input wire logic signed [`SACG_POS_W-1:0] cmd_position,
  input wire logic [`SACG_SPD_W-1:0] cmd_speed,
  input wire logic [`SACG_SPD_W-1:0] max_feed_speed,
  input wire logic cmd_accept,
  input wire logic cmd_refuse,
  input wire logic moving,
  input wire logic signed [`SACG_POS_W-1:0] target_position,
  input wire logic [`SACG_SPD_W-1:0] run_speed,
  input wire sacg_cause_t refuse_cause,
  input wire logic [`SACG_MSG_W-1:0] refuse_msg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // An accepted absolute move lands whole in the motion registers one edge later
  sequence s_abs_take; cmd_accept && cmd_kind == SACG_CMD_ABS; endsequence
  sequence s_abs_run; moving && target_position == $past(cmd_position); endsequence
  a_unconf_refuse: assert property (cmd_valid && !configured |-> cmd_refuse && !cmd_accept)
    else $error("unconfigured axis took a command");
  a_drive_gate: assert property (cmd_valid && (!drive_enable || stop_request) |-> !cmd_accept)
    else $error("command taken without drive");
  a_abs_take: assert property (s_abs_take |=> s_abs_run)
    else $error("absolute move not taken");
  a_speed_ceiling: assert property (cmd_valid && cmd_speed > max_feed_speed |-> !cmd_accept)
    else $error("overspeed command taken");
  a_clamp_speed: assert property ($stable(max_feed_speed) |-> run_speed <= max_feed_speed)
    else $error("run speed above ceiling");
  a_refuse_record: assert property (cmd_refuse |=> |refuse_msg && refuse_msg == {4'h0, refuse_cause})
    else $error("refusal not recorded");
  a_refuse_still: assert property (cmd_refuse |=> $stable(target_position))
    else $error("refused command moved target");
  a_one_answer: assert property (cmd_valid |-> cmd_accept != cmd_refuse)
    else $error("command answer not unique");
endmodule
bind sacg_gate sacg_gate_checker sacg_gate_checker_i (.mclk, .resetn, .configured, .drive_enable, .stop_request,
  .cmd_valid, .cmd_kind, .cmd_position, .cmd_speed, .max_feed_speed, .cmd_accept, .cmd_refuse, .moving,
  .target_position, .run_speed, .refuse_cause, .refuse_msg);
`default_nettype wire

// [tb/sacg_translator_model.sv]
// Stepper translator model that walks the position toward the target
`include "sacg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sacg_translator_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic moving,
  input wire logic cmd_valid,
  input wire logic signed [`SACG_POS_W-1:0] target_position,
  output logic step_done,
  output logic signed [`SACG_POS_W-1:0] current_position
);
  // Done held off while a command is offered, so the two never race at one edge
  assign step_done = moving && !cmd_valid && current_position == target_position;
  // One step a cycle while the axis runs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      current_position <= 32'sh0;
    end else if (moving && current_position != target_position) begin
      current_position <= current_position + ((target_position > current_position) ? 32'sh1 : -32'sh1);
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the step axis command gate
`include "sacg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sacg_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, configured = 1'b1, blocking_error = 1'b0, drive_enable = 1'b1, stop_request = 1'b0;
  logic fault_acknowledge = 1'b0, cmd_valid = 1'b0, cmd_dir_up = 1'b1, sequence_step = 1'b0, internal_fault = 1'b0;
  logic referenced_set = 1'b0, parameter_write_request = 1'b0, adjustment_exchange_pending = 1'b0;
  logic monitor_inversion = 1'b1, drive_ready_pin = 1'b0, eor_low_pin = 1'b0;
  logic ref_m = 1'b0, fault_m = 1'b0, param_write_accept, cmd_accept, cmd_refuse, moving, axis_up, referenced;
  logic step_done, fault_internal, fault_external, fault_other;
  sacg_mode_t mode_select = SACG_MODE_AUTO;
  sacg_cmd_t cmd_kind = SACG_CMD_ABS;
  logic signed [`SACG_POS_W-1:0] cmd_position = 32'h0, current_position, target_position;
  logic signed [`SACG_POS_W-1:0] soft_limit_low = 32'hFFFFFC18, soft_limit_high = 32'h000003E8;
  logic [`SACG_SPD_W-1:0] cmd_speed = 16'h0010, max_feed_speed = 16'h0100, run_speed;
  logic [`SACG_CMV_W-1:0] speed_modulation_coefficient = `SACG_CMV_UNITY;
  logic [`SACG_MSG_W-1:0] refuse_msg;
  sacg_cause_t refuse_cause;
  int err_total = 0, tests_run = 0;
  integer seed = 32'hBC6DF2E1;
  always #2.5 mclk = ~mclk;
  // Monitor inverted with no translator fitted; high end-of-run and sequence option held off
  sacg_gate sacg_gate_i (.mclk, .resetn, .configured, .blocking_error, .drive_enable, .stop_request, .fault_acknowledge,
    .mode_select, .cmd_valid, .cmd_kind, .cmd_dir_up, .cmd_position, .cmd_speed, .sequence_step, .sequence_option(1'b0),
    .soft_limit_low, .soft_limit_high, .max_feed_speed, .speed_modulation_coefficient, .monitor_inversion,
    .drive_ready_pin, .eor_low_pin, .eor_high_pin(1'b0), .internal_fault, .step_done, .current_position,
    .referenced_set, .parameter_write_request, .adjustment_exchange_pending, .param_write_accept, .cmd_accept,
    .cmd_refuse, .moving, .axis_up, .target_position, .run_speed, .referenced, .refuse_cause, .refuse_msg,
    .fault_internal, .fault_external, .fault_other);
  sacg_translator_model sacg_translator_model_i (.mclk, .resetn, .moving, .cmd_valid, .target_position, .step_done,
    .current_position);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Refusal cause by admission priority; position limits only bind absolute and relative moves
  function automatic sacg_cause_t exp_cause(input logic signed [`SACG_POS_W-1:0] tgt, input logic dir);
    return !configured ? SACG_CAUSE_UNCONF : (blocking_error || fault_m) ? SACG_CAUSE_BLOCKED
      : (!drive_enable || stop_request) ? SACG_CAUSE_DRIVE
      : (mode_select != SACG_MODE_AUTO && mode_select != SACG_MODE_MANUAL) ? SACG_CAUSE_MODE
      : (!ref_m && cmd_kind != SACG_CMD_REF && cmd_kind != SACG_CMD_INCH) ? SACG_CAUSE_UNREF
      : (cmd_kind <= SACG_CMD_REL && (tgt < soft_limit_low || tgt > soft_limit_high)) ? SACG_CAUSE_LIMIT
      : (cmd_speed > max_feed_speed) ? SACG_CAUSE_SPEED : (eor_low_pin && !dir) ? SACG_CAUSE_EOR : SACG_CAUSE_NONE;
  endfunction
  // Offers the staged command for one cycle
  task automatic issue();
    sacg_cause_t c;
    logic signed [`SACG_POS_W-1:0] t;
    logic d;
    t = (cmd_kind == SACG_CMD_REL) ? current_position + cmd_position
      : (cmd_kind == SACG_CMD_CONT) ? (cmd_dir_up ? soft_limit_high : soft_limit_low) : cmd_position;
    d = (cmd_kind <= SACG_CMD_REL) ? t > current_position : cmd_dir_up;
    c = exp_cause(t, d);
    cmd_valid = 1'b1;
    #1;
    check(cmd_accept, c == SACG_CAUSE_NONE);
    @(negedge mclk);
    cmd_valid = 1'b0;
    if (c != SACG_CAUSE_NONE) begin
      check(refuse_msg, c);
      check(refuse_cause, c);
    end else begin
      check(moving, 1'b1);
      check(target_position, t);
      check(axis_up, d);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the under one thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    summarize();
  end
  initial begin
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    repeat (5) @(negedge mclk);
    check(fault_external, 1'b0);
    issue();
    cmd_kind = SACG_CMD_INCH;
    @(negedge mclk);
    issue();
    {referenced_set, ref_m} = 2'h3;
    @(negedge mclk);
    referenced_set = 1'b0;
    check(referenced, 1'b1);
    for (int i = 0; i < 400; i++) begin
      mode_select = sacg_mode_t'($unsigned($random(seed)) % 4);
      cmd_kind = sacg_cmd_t'($unsigned($random(seed)) % 5);
      {cmd_dir_up, parameter_write_request, adjustment_exchange_pending} = 3'($random(seed));
      // Reference and inching targets stay inside the limits, so a direct-drive pick never finds an overrun
      cmd_position = $random(seed) % ((cmd_kind >= SACG_CMD_REF) ? 1000 : 1200);
      cmd_speed = max_feed_speed - 16'h0002 + 16'($unsigned($random(seed)) % 4);
      @(negedge mclk);
      issue();
      check(param_write_accept, parameter_write_request && !adjustment_exchange_pending);
    end
    // Doubled coefficient on a full-speed continuous move must clamp; a sequence step must not end it
    mode_select = SACG_MODE_MANUAL;
    cmd_kind = SACG_CMD_CONT;
    cmd_speed = max_feed_speed;
    speed_modulation_coefficient = 16'h07D0;
    cmd_dir_up = current_position < 0;
    @(negedge mclk);
    issue();
    sequence_step = 1'b1;
    @(negedge mclk);
    sequence_step = 1'b0;
    check(run_speed, max_feed_speed);
    check(moving, 1'b1);
    {fault_acknowledge, stop_request, internal_fault} = 3'h7;
    repeat (3) @(negedge mclk);
    check({moving, fault_internal, fault_external}, 3'h3);
    {stop_request, internal_fault, fault_acknowledge, fault_m} = 4'h1;
    issue();
    {fault_acknowledge, fault_m} = 2'h2;
    repeat (2) @(negedge mclk);
    check({fault_internal, fault_external, fault_other}, 3'h0);
    // Resting on the low end-of-run: a downward inch is refused, an upward one runs
    eor_low_pin = 1'b1;
    cmd_kind = SACG_CMD_INCH;
    cmd_dir_up = 1'b0;
    cmd_position = 32'sh0;
    repeat (5) @(negedge mclk);
    issue();
    cmd_dir_up = 1'b1;
    @(negedge mclk);
    issue();
    eor_low_pin = 1'b0;
    for (int i = 0; i < 3; i++) begin
      {configured, blocking_error, drive_enable} = (i == 0) ? 3'h1 : (i == 1) ? 3'h7 : 3'h4;
      @(negedge mclk);
      issue();
    end
    summarize();
  end
endmodule
`default_nettype wire
